// File: design/ulr_phy_ctrl.sv
// ulpi device-side protocol block: register access and receive commands
// Functional notes
// - next raised two cycles after command
// - register written after stop, next drops
// - direction stays low through a write
// - extended write: address then data
// - read: next, then direction up, next down
// - turnaround, one data cycle, direction drops
// - extended read uses address 2Fh
// - receive commands only synchronous or during packet receive, direction high
// - line state change sends receive command
// - during receive, insert when next low
// - during transmit, defer until stop
// - vbus or id change sends receive command
// - send after startup and mode exit
// - bits 1:0 carry line state
// - bits 3:2 carry vbus band code
// - turnaround cycle on each direction change
// - line bit0 is dp, bit1 is dm
// - bit 6 is the id pin level
// - bit 7 is carkit interrupt flag
`timescale 1ns/1ps
`default_nettype none
module ulr_phy_ctrl #(
   parameter int AW = ulr_pkg::REG_ADDR_W,
   parameter int DW = ulr_pkg::REG_DATA_W
) (
   // clock, enable and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // ulpi link side, data bus split into in, out and enable
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic dir,
   output logic nxt,
   input wire logic stp,
   // analog pins and detectors, asynchronous
   input wire logic dp_rx,
   input wire logic dm_rx,
   input wire logic id_pin,
   input wire logic [1:0] vbus_band,
   // internal status from same-clock logic
   input wire logic sync_mode,
   input wire logic alt_int,
   input wire logic [1:0] rx_event,
   input wire logic usb_rx_active,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic startup_done,
   input wire logic mode_exit,
   // observation of the register file and of the transmit state
   output logic reg_wr_pulse,
   output logic [AW-1:0] reg_wr_addr,
   output logic [DW-1:0] reg_wr_data,
   output logic xmit_active
);
   ulr_pkg::ulr_state_t state_reg, state_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic [DW-1:0] wdata_reg, wdata_next;
   logic is_read_reg, is_read_next;
   logic pending_reg;
   logic [7:0] last_status_reg;
   logic [7:0] dout_reg, dout_next;
   logic [1:0] dp_sync, dm_sync, id_sync;
   logic [1:0] vb_sync0, vb_sync1;
   logic [7:0] rd_value;
   logic rx_nxt_reg;

   // elaboration check: the command byte fixes data at 8 bits, addresses at 6 to 8
   if (AW < 6 || AW > 8 || DW != 8)
      $error("ulr_phy_ctrl: address 6..8 bits, data 8 bits");

   // two-stage synchronisers for the pin inputs
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         dp_sync <= 2'h0;
         dm_sync <= 2'h0;
         id_sync <= 2'h0;
         vb_sync0 <= 2'h0;
         vb_sync1 <= 2'h0;
      end
      else if (clk_en)
      begin
         dp_sync <= {dp_sync[0], dp_rx};
         dm_sync <= {dm_sync[0], dm_rx};
         id_sync <= {id_sync[0], id_pin};
         vb_sync0 <= vbus_band;
         vb_sync1 <= vb_sync0;
      end
   end

   // receive command byte assembled from current status
   wire [7:0] status_byte = {alt_int, id_sync[1], rx_event, vb_sync1, dm_sync[1], dp_sync[1]};
   wire status_changed = status_byte != last_status_reg;
   wire [1:0] cmd_type = data_in[ulr_pkg::CMD_TYPE_HI:ulr_pkg::CMD_TYPE_LO];
   wire is_ext = data_in[5:0] == ulr_pkg::EXT_ADDR_CODE;
   wire cmd_reg = cmd_type == ulr_pkg::CMD_REGWR || cmd_type == ulr_pkg::CMD_REGRD;
   wire cmd_xmit = cmd_type == ulr_pkg::CMD_XMIT;
   wire may_send = sync_mode && pending_reg;
   wire wr_commit = state_reg == ulr_pkg::ST_WR_STOP && !stp && clk_en;
   // packet byte offered now is on the bus next cycle, nxt must follow it
   wire rx_nxt_next = state_reg == ulr_pkg::ST_RX_SEND && rx_byte_valid;

   // pending flag: start-up or mode-exit requests win over the clear; a status
   // change in the sending cycle is already in the byte latched, so no repeat
   wire send_now = state_reg == ulr_pkg::ST_RX_TURN
                   || (state_reg == ulr_pkg::ST_RX_SEND && usb_rx_active && !rx_byte_valid);
   wire fresh_change = status_changed && !send_now;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pending_reg <= 1'b0;
         last_status_reg <= ulr_pkg::RST_BYTE;
      end
      else if (clk_en)
      begin
         if (fresh_change || startup_done || mode_exit)
            pending_reg <= 1'b1;
         else if (send_now)
            pending_reg <= 1'b0;
         if (send_now)
            last_status_reg <= status_byte;
      end
   end

   // next-state and output decode of the bus controller
   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      is_read_next = is_read_reg;
      dout_next = ulr_pkg::IDLE_BYTE;
      case (state_reg)
         ulr_pkg::ST_IDLE:
         begin
            // link commands only read while direction low
            if (usb_rx_active)
            begin
               state_next = ulr_pkg::ST_RX_TURN;
            end
            else if (cmd_reg)
            begin
               is_read_next = cmd_type == ulr_pkg::CMD_REGRD;
               addr_next = AW'(data_in[5:0]);
               state_next = ulr_pkg::ST_CMD_WAIT;
               if (is_ext)
                  addr_next = AW'(ulr_pkg::EXT_ADDR_CODE);
            end
            else if (cmd_xmit)
               state_next = ulr_pkg::ST_TX;
            else if (may_send)
               state_next = ulr_pkg::ST_RX_TURN;
         end
         ulr_pkg::ST_CMD_WAIT:
            state_next = ulr_pkg::ST_NXT;
         ulr_pkg::ST_NXT:
         begin
            // next is high here; decode what the link does now
            if (addr_reg == AW'(ulr_pkg::EXT_ADDR_CODE))
               state_next = ulr_pkg::ST_EXT_ADDR;
            else if (is_read_reg)
               state_next = ulr_pkg::ST_RD_TURN;
            else
               state_next = ulr_pkg::ST_WR_DATA;
         end
         ulr_pkg::ST_EXT_ADDR:
         begin
            addr_next = AW'(data_in);
            state_next = is_read_reg ? ulr_pkg::ST_RD_TURN : ulr_pkg::ST_WR_DATA;
         end
         ulr_pkg::ST_WR_DATA:
         begin
            wdata_next = data_in;
            state_next = ulr_pkg::ST_WR_STOP;
         end
         ulr_pkg::ST_WR_STOP:
            if (!stp)
               state_next = ulr_pkg::ST_IDLE;
         ulr_pkg::ST_RD_TURN:
         begin
            dout_next = rd_value;
            state_next = ulr_pkg::ST_RD_DATA;
         end
         ulr_pkg::ST_RD_DATA:
            state_next = ulr_pkg::ST_BACK_TURN;
         ulr_pkg::ST_RX_TURN:
         begin
            dout_next = status_byte;
            state_next = ulr_pkg::ST_RX_SEND;
         end
         ulr_pkg::ST_RX_SEND:
         begin
            dout_next = rx_byte_valid ? rx_byte : status_byte;
            if (usb_rx_active || rx_byte_valid)
               state_next = ulr_pkg::ST_RX_SEND;
            else
               state_next = ulr_pkg::ST_BACK_TURN;
            if (rx_byte_valid)
               dout_next = rx_byte;
            else
               dout_next = status_byte;
         end
         ulr_pkg::ST_TX:
            if (stp)
               state_next = ulr_pkg::ST_IDLE;
         ulr_pkg::ST_BACK_TURN:
            state_next = ulr_pkg::ST_IDLE;
         default:
            state_next = ulr_pkg::ST_IDLE;
      endcase
   end

   // state registers, frozen while clock enable is low
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ulr_pkg::ST_IDLE;
         addr_reg <= '0;
         wdata_reg <= '0;
         is_read_reg <= 1'b0;
         dout_reg <= ulr_pkg::RST_BYTE;
         rx_nxt_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         is_read_reg <= is_read_next;
         dout_reg <= dout_next;
         rx_nxt_reg <= rx_nxt_next;
      end
   end

   ulr_regmem #(
      .AW(AW),
      .DW(DW)
   ) u_mem (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .wr_en(wr_commit),
      .wr_addr(addr_reg),
      .wr_data(wdata_reg),
      .rd_addr(addr_next), // read ahead so an extended read sees its new address
      .rd_data(rd_value)
   );

   // bus handshake outputs decoded from the state
   // direction low through write states; a turnaround precedes data
   assign dir = state_reg == ulr_pkg::ST_RD_TURN || state_reg == ulr_pkg::ST_RD_DATA
                || state_reg == ulr_pkg::ST_RX_TURN || state_reg == ulr_pkg::ST_RX_SEND;
   assign nxt = state_reg == ulr_pkg::ST_NXT || state_reg == ulr_pkg::ST_EXT_ADDR
                || state_reg == ulr_pkg::ST_WR_DATA
                || (state_reg == ulr_pkg::ST_WR_STOP && stp)
                || (state_reg == ulr_pkg::ST_RX_SEND && rx_nxt_reg);
   // bus driven only after the turnaround cycle
   assign data_oe = state_reg == ulr_pkg::ST_RD_DATA || state_reg == ulr_pkg::ST_RX_SEND;
   assign data_out = dout_reg;
   assign reg_wr_pulse = wr_commit;
   assign reg_wr_addr = addr_reg;
   assign reg_wr_data = wdata_reg;
   assign xmit_active = state_reg == ulr_pkg::ST_TX;
endmodule
`default_nettype wire

// File: design/ulr_pkg.sv
// shared constants for the ulpi register access and receive command block
package ulr_pkg;
   // transmit command byte fields
   localparam logic [1:0] CMD_IDLE = 2'h0;
   localparam logic [1:0] CMD_XMIT = 2'h1;
   localparam logic [1:0] CMD_REGWR = 2'h2;
   localparam logic [1:0] CMD_REGRD = 2'h3;
   localparam int CMD_TYPE_HI = 7;
   localparam int CMD_TYPE_LO = 6;
   localparam logic [5:0] EXT_ADDR_CODE = 6'h2F;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   // receive command byte fields
   localparam int RXC_LINE_LO = 0;
   localparam int RXC_VBUS_LO = 2;
   localparam int RXC_EVT_LO = 4;
   localparam int RXC_ID_BIT = 6;
   localparam int RXC_ALT_BIT = 7;
   // vbus band codes
   localparam logic [1:0] VB_BELOW_END = 2'h0;
   localparam logic [1:0] VB_END_TO_SESS = 2'h1;
   localparam logic [1:0] VB_SESS_TO_VLD = 2'h2;
   localparam logic [1:0] VB_ABOVE_VLD = 2'h3;
   // reset values and register widths
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 8;
   // bus controller states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_CMD_WAIT = 4'h1,
      ST_NXT = 4'h2,
      ST_EXT_ADDR = 4'h3,
      ST_WR_DATA = 4'h4,
      ST_WR_STOP = 4'h5,
      ST_RD_TURN = 4'h6,
      ST_RD_DATA = 4'h7,
      ST_RX_TURN = 4'h8,
      ST_RX_SEND = 4'h9,
      ST_TX = 4'hA,
      ST_BACK_TURN = 4'hB
   } ulr_state_t;
endpackage

// File: design/ulr_regmem.sv
// register array behind the ulpi register access, registered read data
`timescale 1ns/1ps
`default_nettype none
module ulr_regmem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   // read port
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // elaboration check on the address widths the bus can carry
   if (AW < 6 || AW > 8)
      $error("ulr_regmem: address width must be 6 to 8");

   // storage has no reset; contents survive mode changes
   always_ff @(posedge sys_clk)
   begin
      if (clk_en && wr_en)
         mem[wr_addr] <= wr_data;
   end

   // read data out of a flip-flop
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rd_data <= '0;
      else if (clk_en)
         rd_data <= mem[rd_addr];
   end
endmodule
`default_nettype wire

// File: tb/ulr_phy_ctrl_checker.sv
// port assertions for the ulpi device block
`timescale 1ns/1ps
`default_nettype none
module ulr_phy_ctrl_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // ulpi bus
   input wire logic [7:0] data_in,
   input wire logic data_oe,
   input wire logic dir,
   input wire logic nxt,
   input wire logic stp,
   // status
   input wire logic sync_mode,
   input wire logic usb_rx_active,
   input wire logic rx_byte_valid,
   input wire logic reg_wr_pulse,
   input wire logic xmit_active
);
   logic idle_q;
   // a command counts only after an idle byte, so data bytes never look like commands
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         idle_q <= 1'b0;
      else
         idle_q <= !dir && !nxt && data_in == 8'h00;
   end
   wire cmd_take = idle_q && !dir && !nxt && !usb_rx_active && data_in[7:6] != 2'h0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // only register commands get the nxt answer; transmit waits for stop
   cmd_nxt_a: assert property (cmd_take && data_in[7] |-> ##1 !nxt ##1 nxt)
      else $error("nxt late after command");
   wr_dir_a: assert property (cmd_take && data_in[7:6] == 2'h2 |-> !dir [*6])
      else $error("dir rose during write");
   wr_commit_a: assert property (reg_wr_pulse |->
      !nxt && !stp && $past(stp) && $past(nxt))
      else $error("commit without stop release");
   rd_seq_a: assert property (cmd_take && data_in[7:6] == 2'h3 && data_in[5:0] != 6'h2F |->
      ##2 nxt && !dir ##1 dir && !nxt && !data_oe ##1 data_oe ##1 !dir && !data_oe)
      else $error("read handshake out of order");
   turn_in_a: assert property (data_oe |-> dir && $past(dir))
      else $error("bus driven in turnaround");
   one_byte_a: assert property (data_oe && !usb_rx_active |=> !data_oe)
      else $error("device drove more than one byte");
   sync_only_a: assert property ($rose(dir) && !$past(nxt) && !usb_rx_active |-> sync_mode)
      else $error("status byte outside synchronous mode");
   xmit_hold_a: assert property (xmit_active && !stp |=> !dir)
      else $error("bus taken during transmit");
   // a packet byte offered at one edge is on the bus, with nxt, in the next cycle
   rx_fill_a: assert property (usb_rx_active && dir && $past(dir) && $past(dir, 2) |->
      nxt == $past(rx_byte_valid))
      else $error("status byte collided with packet byte");
   // main scenarios reached
   cover property (reg_wr_pulse);
   cover property (cmd_take && data_in[7:6] == 2'h3);
   cover property (xmit_active ##1 stp);
endmodule
bind ulr_phy_ctrl ulr_phy_ctrl_checker i_chk (.sys_clk, .rst, .data_in, .data_oe, .dir, .nxt,
   .stp, .sync_mode, .usb_rx_active, .rx_byte_valid, .reg_wr_pulse, .xmit_active);
`default_nettype wire

// File: tb/ulr_link_model.sv
// link-side model driving the ulpi bus toward the device
`timescale 1ns/1ps
`default_nettype none
module ulr_link_model (
   // clock
   input wire logic sys_clk,
   // device side
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic dir,
   input wire logic nxt,
   // resolved bus and stop
   output logic [7:0] data_in,
   output var logic stp
);
   logic [7:0] lk_byte = 8'h00;
   logic [7:0] pat = 8'h5A;
   logic dir_q = 1'b0;
   logic s_nxt;
   logic s_dir;
   logic [7:0] s_bus;
   initial stp = 1'b0;
   // undriven bus shows a pattern changing every cycle, not a stale value
   always_ff @(posedge sys_clk)
   begin
      dir_q <= dir;
      pat <= ~pat + 8'h01;
   end
   assign data_in = data_oe ? data_out : (!dir && !dir_q) ? lk_byte : pat;
   // sample at the edge, then move just after it
   task step();
      @(posedge sys_clk);
      s_nxt = nxt;
      s_dir = dir;
      s_bus = data_in;
      #2;
   endtask
   // hold a byte until an edge sees nxt high
   task put(input logic [7:0] v);
      lk_byte = v;
      step();
      while (!s_nxt)
         step();
   endtask
   // register write, extended form when ext is set
   task reg_write(input logic ext, input logic [7:0] a, input logic [7:0] d);
      step();
      while (s_dir)
         step();
      put(ext ? 8'hAF : {2'h2, a[5:0]});
      if (ext)
         put(a);
      put(d);
      lk_byte = 8'h00;
      stp = 1'b1;
      step();
      stp = 1'b0;
      step();
   endtask
   // register read, data taken in the cycle after turnaround
   task reg_read(input logic ext, input logic [7:0] a, output logic [7:0] d);
      step();
      while (s_dir)
         step();
      put(ext ? 8'hEF : {2'h3, a[5:0]});
      if (ext)
         put(a);
      lk_byte = 8'h00;
      while (!s_dir)
         step();
      step();
      d = s_bus;
      step();
      step();
   endtask
   // transmit held open, then closed with a stop
   task xmit();
      step();
      while (s_dir)
         step();
      lk_byte = 8'h40;
      step();
      lk_byte = 8'h00;
      repeat (6)
         step();
      stp = 1'b1;
      step();
      stp = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/ulpi_register_access_rxcmd_test.sv
// self-checking bench for the ulpi device block
`timescale 1ns/1ps
`default_nettype none
module ulpi_register_access_rxcmd_test;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic dp_rx = 1'b0;
   logic dm_rx = 1'b0;
   logic id_pin = 1'b0;
   logic [1:0] vbus_band = 2'h0;
   logic sync_mode = 1'b1;
   logic alt_int = 1'b0;
   logic [1:0] rx_event = 2'h0;
   logic usb_rx_active = 1'b0;
   logic rx_byte_valid = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic startup_done = 1'b0;
   logic mode_exit = 1'b0;
   logic [7:0] data_in, data_out, reg_wr_addr, reg_wr_data, a, d, r;
   logic data_oe, dir, nxt, stp, reg_wr_pulse, xmit_active;
   logic [7:0] mem [logic [7:0]];
   int failures = 0;
   int n_checks = 0;
   int i, k;
   ulr_phy_ctrl i_dut (.sys_clk, .rst, .clk_en(1'b1), .data_in, .data_out, .data_oe, .dir,
      .nxt, .stp, .dp_rx, .dm_rx, .id_pin, .vbus_band, .sync_mode, .alt_int, .rx_event,
      .usb_rx_active, .rx_byte_valid, .rx_byte, .startup_done, .mode_exit, .reg_wr_pulse,
      .reg_wr_addr, .reg_wr_data, .xmit_active);
   ulr_link_model i_link (.sys_clk, .data_out, .data_oe, .dir, .nxt, .data_in, .stp);
   // 50 ns clock
   initial
   begin
      forever
         #25 sys_clk = ~sys_clk;
   end
   // count a comparison and report a difference
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // status byte the device should report for the present inputs
   function logic [7:0] rxc();
      return {alt_int, id_pin, rx_event, vbus_band, dm_rx, dp_rx};
   endfunction
   // bounded wait for a driven status byte, compared in its one cycle
   task rxwait();
      k = 0;
      @(posedge sys_clk);
      while (data_oe !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk);
         k++;
      end
      chk("rxcmd", data_out, rxc());
      #2;
   endtask
   task end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // cut a hang short; the whole run needs well under a thousand cycles
   initial
   begin
      repeat (5000)
         @(posedge sys_clk);
      failures++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      void'($urandom(32'hC0597F30));
      repeat (16)
         @(posedge sys_clk);
      #2 rst = 1'b0;
      // writes back to back, odd ones extended; 2F kept out of immediate addresses
      for (i = 0; i < 8; i++)
      begin
         a = i[0] ? 8'($urandom) : {2'h0, 6'($urandom % 47)};
         d = 8'($urandom);
         i_link.reg_write(i[0], a, d);
         chk("wr_addr", reg_wr_addr, a);
         chk("wr_data", reg_wr_data, d);
         mem[a] = d;
      end
      foreach (mem[j])
      begin
         i_link.reg_read(j > 8'h3F || j == 8'h2F, j, r);
         chk("rd_data", r, mem[j]);
      end
      // every vbus band, line and id change gives a status byte
      for (i = 1; i < 9; i++)
      begin
         {alt_int, id_pin, rx_event, dm_rx} = 5'($urandom);
         vbus_band = i[1:0];
         dp_rx = i[0];
         rxwait();
      end
      // held back outside synchronous mode
      sync_mode = 1'b0;
      dp_rx = ~dp_rx;
      repeat (8)
      begin
         @(posedge sys_clk);
         chk("dir_async", {7'h00, dir}, 8'h00);
      end
      #2 sync_mode = 1'b1;
      rxwait();
      startup_done = 1'b1;
      @(posedge sys_clk);
      #2 startup_done = 1'b0;
      rxwait();
      mode_exit = 1'b1;
      @(posedge sys_clk);
      #2 mode_exit = 1'b0;
      rxwait();
      // line change in mid transmit waits for the stop
      fork
         i_link.xmit();
         begin
            repeat (5)
               @(posedge sys_clk);
            #2 dm_rx = ~dm_rx;
         end
      join
      chk("xmit", {7'h00, xmit_active}, 8'h00);
      rxwait();
      // packet reception with random gaps for status bytes
      usb_rx_active = 1'b1;
      dp_rx = ~dp_rx;
      // a byte offered at one edge returns with nxt a cycle later; gaps carry status
      for (i = 0; i < 30; i++)
      begin
         @(posedge sys_clk);
         if (data_oe && nxt)
            chk("rx_byte", data_out, r);
         else if (data_oe && i > 4)
            chk("rx_status", data_out, rxc());
         r = rx_byte;
         #2 rx_byte_valid = 1'($urandom);
         rx_byte = 8'($urandom);
      end
      @(posedge sys_clk);
      #2 rx_byte_valid = 1'b0;
      usb_rx_active = 1'b0;
      repeat (6)
         @(posedge sys_clk);
      end_of_test();
   end
endmodule
`default_nettype wire
